// *** design/sleep_pkg.sv ***
`default_nettype none
package sleep_pkg;
   // ======================================================================
   // Register map, byte offsets on the plain register port.
   // ======================================================================
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 8;
   localparam logic [7:0]  SLEEP_CONTROL_OFF = 8'h33;
   localparam logic [7:0]  GATE0_OFF         = 8'h64;
   localparam logic [7:0]  GATE1_OFF         = 8'h65;
   localparam logic [7:0]  MCU_CONTROL_OFF   = 8'h35;
   localparam logic [7:0]  INDIS0_OFF        = 8'h7e;
   localparam logic [7:0]  INDIS1_OFF        = 8'h7f;
   localparam logic [7:0]  INDIS2_OFF        = 8'h7d;
   localparam logic [7:0]  STATUS_OFF        = 8'h36;

   // ======================================================================
   // Field layouts and reset values.
   // ======================================================================
   localparam logic [7:0]  SLEEP_CONTROL_WMASK = 8'h0f;
   localparam logic [7:0]  GATE0_WMASK         = 8'hef;
   localparam logic [7:0]  GATE1_WMASK         = 8'h3f;
   localparam logic [7:0]  MCU_CONTROL_WMASK   = 8'h80;
   localparam logic [7:0]  REG_RESET           = 8'h00;
   localparam int          SLEEP_ENABLE_BIT    = 0;
   localparam int          MODE_LSB            = 1;
   localparam int          DEBUG_DISABLE_BIT   = 7;
   localparam int          G0_TWO_WIRE         = 7;
   localparam int          G0_TIMER2           = 6;
   localparam int          G0_TIMER0           = 5;
   localparam int          G0_TIMER1           = 3;
   localparam int          G0_SPI              = 2;
   localparam int          G0_SERIAL0          = 1;
   localparam int          G0_CONVERTER        = 0;

   // ======================================================================
   // Sleep modes and timing.
   // ======================================================================
   localparam logic [2:0]  MODE_IDLE     = 3'h0;
   localparam logic [2:0]  MODE_NOISE    = 3'h1;
   localparam logic [2:0]  MODE_PDOWN    = 3'h2;
   localparam logic [2:0]  MODE_PSAVE    = 3'h3;
   localparam logic [2:0]  MODE_STANDBY  = 3'h6;
   localparam logic [2:0]  MODE_XSTANDBY = 3'h7;
   localparam int          WAKE_HALT_CYCLES    = 4;
   localparam int          STANDBY_WAKE_CYCLES = 6;
   localparam int          STARTUP_CYCLES      = 16;
   localparam logic [2:0]  BROWNOUT_OFF_CODE   = 3'h7;

   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} pwr_state_t;
endpackage
`default_nettype wire

// *** design/sleep_mode_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_decode
(
   // Mode in
   input  wire logic [2:0] mode,
   // Clock domains kept
   output logic            ioClkRun,
   output logic            adcClkRun,
   output logic            oscRun,
   output logic            timer2Run,
   output logic            shallow,
   output logic            fastWake
);
   import sleep_pkg::*;

   always_comb
   begin
      ioClkRun  = (mode == MODE_IDLE);
      adcClkRun = (mode == MODE_IDLE) || (mode == MODE_NOISE);
      oscRun    = (mode == MODE_IDLE) || (mode == MODE_NOISE)
                  || (mode == MODE_STANDBY) || (mode == MODE_XSTANDBY);
      timer2Run = (mode == MODE_NOISE) || (mode == MODE_PSAVE)
                  || (mode == MODE_XSTANDBY) || (mode == MODE_IDLE);
      shallow   = adcClkRun;
      fastWake  = (mode == MODE_STANDBY) || (mode == MODE_XSTANDBY);
   end
endmodule
`default_nettype wire

// *** design/wake_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module wake_counter
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   // Control
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic                  done
);
   logic [WIDTH-1:0] count_q;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         count_q <= '0;
      else if (load)
         count_q <= loadValue;
      else if (count_q != '0)
         count_q <= count_q - WIDTH'(1);
   end

   assign done = (count_q == WIDTH'(1));
endmodule
`default_nettype wire

// *** design/sleep_and_power_reduction_ctrl.sv ***
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Sleep control resets to zero; upper nibble reads zero, lower nibble writable.
// - Three mode bits pick idle, noise, power-down, save, standby, extended.
// - Sleep instruction sleeps only while the sleep-enable bit is one.
// - Gate register 0 resets to zero; bit 4 always reads zero.
// - Gate 0 bit 7 stops the two-wire interface clock.
// - Gate 0 bit 6 stops timer 2 only when clocked synchronously.
// - Gate 0 bits 5 and 3 freeze timers 0 and 1.
// - Gate 0 bit 2 stops the SPI clock.
// - Gate 0 bit 1 stops serial port 0 clock.
// - Gate 0 bit 0 shuts converter; comparator loses converter multiplexer.
// - Gate register 1 bits 7 and 6 read zero.
// - Gate 1 bits 5, 4, 3 freeze timers 5, 4, 3.
// - Gate 1 bits 2, 1, 0 stop serial ports 3, 2, 1.
// - Enabled converter stays on in sleep; restart forces extended conversion.
// - Comparator auto-disabled in deep modes; its reference use keeps reference.
// - Reference powered when brown-out, comparator or converter needs it.
// - Brown-out detector enabled by level stays on in every sleep mode.
// - Enabled watchdog keeps running in every sleep mode.
// - Input buffers off when I/O and converter clocks stop, except wake pins.
// - Enabled debug keeps main clock in sleep; disable bit turns debug off.
// - Input-disable registers turn off digital buffers of analog pins.
// - Interrupt wake halts CPU four cycles beyond start-up time.
// - Idle stops only CPU and flash clocks.
// - Standby modes keep oscillator running and wake in six cycles.
// - Gated peripheral is frozen and its registers inaccessible.
module sleep_and_power_reduction_ctrl
#(
   parameter int STARTUP = sleep_pkg::STARTUP_CYCLES
)
(
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        resetn,
   // Register port
   input  wire logic [sleep_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [sleep_pkg::DATA_W-1:0] regWdata,
   input  wire logic                        regWrite,
   input  wire logic                        regRead,
   output logic      [sleep_pkg::DATA_W-1:0] regRdata,
   // CPU core
   input  wire logic                        sleepInstr,
   input  wire logic                        wakeEvent,
   output logic                             cpuRun,
   output logic                             flashClkEn,
   output logic                             sleeping,
   // Configuration and peripheral status
   input  wire logic                        timer2AsyncSelect,
   input  wire logic [2:0]                  brownoutLevelConfig,
   input  wire logic                        debugEnableConfig,
   input  wire logic                        scanPortEnableConfig,
   input  wire logic                        watchdogEnabled,
   input  wire logic                        converterEnabled,
   input  wire logic                        comparatorEnabled,
   input  wire logic                        comparatorUsesRef,
   input  wire logic                        comparatorUsesMux,
   input  wire logic [7:0]                  wakePinMask,
   // Clock enables, analog, supervisory, debug and input-buffer controls
   output logic                             ioClkEn,
   output logic                             adcClkEn,
   output logic                             oscEn,
   output logic                             clkTwoWire,
   output logic                             clkTimer0,
   output logic                             clkTimer1,
   output logic                             clkTimer2,
   output logic                             clkTimer3,
   output logic                             clkTimer4,
   output logic                             clkTimer5,
   output logic                             clkSpi,
   output logic [3:0]                       clkSerial,
   output logic                             converterOn,
   output logic                             converterExtended,
   output logic                             comparatorOn,
   output logic                             comparatorMuxOk,
   output logic                             referenceOn,
   output logic                             brownoutOn,
   output logic                             watchdogRun,
   output logic                             debugActive,
   output logic [7:0]                       inputBufEn,
   output logic [23:0]                      inputDisable
);
   import sleep_pkg::*;

   if (STARTUP < 1 || STARTUP > 250)
      $error("STARTUP out of range");

   // ======================================================================
   // Registers.
   // ======================================================================
   logic [7:0] sleepControl_q, gate0_q, gate1_q, mcuControl_q;
   logic [7:0] indis0_q, indis1_q, indis2_q;
   pwr_state_t state_q;
   logic       convSeen_q;

   function automatic logic [7:0] wr(input logic [7:0] old, input logic [7:0] mask,
                                     input logic [7:0] data);
      wr = (old & ~mask) | (data & mask);
   endfunction

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = regWrite && (addr == off);
   endfunction

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sleepControl_q <= REG_RESET;
         gate0_q        <= REG_RESET;
         gate1_q        <= REG_RESET;
         mcuControl_q   <= REG_RESET;
         indis0_q       <= REG_RESET;
         indis1_q       <= REG_RESET;
         indis2_q       <= REG_RESET;
      end
      else
      begin
         if (hit(regAddr, SLEEP_CONTROL_OFF))
            sleepControl_q <= wr(sleepControl_q, SLEEP_CONTROL_WMASK, regWdata);
         if (hit(regAddr, GATE0_OFF))
            gate0_q <= wr(gate0_q, GATE0_WMASK, regWdata);
         if (hit(regAddr, GATE1_OFF))
            gate1_q <= wr(gate1_q, GATE1_WMASK, regWdata);
         if (hit(regAddr, MCU_CONTROL_OFF))
            mcuControl_q <= wr(mcuControl_q, MCU_CONTROL_WMASK, regWdata);
         if (hit(regAddr, INDIS0_OFF))
            indis0_q <= regWdata;
         if (hit(regAddr, INDIS1_OFF))
            indis1_q <= regWdata;
         if (hit(regAddr, INDIS2_OFF))
            indis2_q <= regWdata;
      end
   end

   // ======================================================================
   // Read port: data stand in the cycle after the strobe, zero otherwise.
   // ======================================================================
   logic [7:0] rdMux;

   always_comb
   begin
      case (regAddr)
         SLEEP_CONTROL_OFF: rdMux = sleepControl_q & SLEEP_CONTROL_WMASK;
         GATE0_OFF:         rdMux = gate0_q & GATE0_WMASK;
         GATE1_OFF:         rdMux = gate1_q & GATE1_WMASK;
         MCU_CONTROL_OFF:   rdMux = mcuControl_q & MCU_CONTROL_WMASK;
         INDIS0_OFF:        rdMux = indis0_q;
         INDIS1_OFF:        rdMux = indis1_q;
         INDIS2_OFF:        rdMux = indis2_q;
         STATUS_OFF:        rdMux = {5'h00, convSeen_q, state_q};
         default:           rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         regRdata <= 8'h00;
      else
         regRdata <= regRead ? rdMux : 8'h00;
   end

   // ======================================================================
   // Sleep sequencer.
   // ======================================================================
   logic [2:0] mode;
   logic [7:0] cntValue;
   logic       ioRun, adcRun, oscRunMode, t2Run, shallow, fastWake;
   logic       cntLoad, cntDone;

   assign mode = sleepControl_q[MODE_LSB +: 3];

   sleep_mode_decode u_decode
   (
      .mode      (mode),
      .ioClkRun  (ioRun),
      .adcClkRun (adcRun),
      .oscRun    (oscRunMode),
      .timer2Run (t2Run),
      .shallow   (shallow),
      .fastWake  (fastWake)
   );

   wake_counter #(.WIDTH(8)) u_wake
   (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .load      (cntLoad),
      .loadValue (cntValue),
      .done      (cntDone)
   );

   logic sleepOk;
   // Reserved codes are treated as no sleep so the core never hangs.
   assign sleepOk = sleepControl_q[SLEEP_ENABLE_BIT] && (mode[2:1] != 2'b10);

   always_comb
   begin
      cntLoad  = 1'b0;
      cntValue = 8'h00;
      if (state_q == ST_SLEEP && wakeEvent)
      begin
         cntLoad  = 1'b1;
         cntValue = (oscRunMode || fastWake) ? 8'(STANDBY_WAKE_CYCLES) : 8'(STARTUP);
      end
      else if (state_q == ST_START && cntDone)
      begin
         cntLoad  = 1'b1;
         cntValue = 8'(WAKE_HALT_CYCLES);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         state_q <= ST_RUN;
      else
      begin
         case (state_q)
            ST_RUN:   if (sleepInstr && sleepOk) state_q <= ST_SLEEP;
            ST_SLEEP: if (wakeEvent) state_q <= ST_START;
            ST_START: if (cntDone) state_q <= ST_HALT;
            ST_HALT:  if (cntDone) state_q <= ST_RUN;
            default:  state_q <= ST_RUN;
         endcase
      end
   end

   logic asleep;
   assign asleep = (state_q != ST_RUN);

   // ======================================================================
   // Clock and power outputs.
   // ======================================================================
   logic debugOn, refNeed, compOn;
   assign debugOn = debugEnableConfig && scanPortEnableConfig
                    && !mcuControl_q[DEBUG_DISABLE_BIT];
   assign compOn  = comparatorEnabled && (!asleep || shallow);
   assign refNeed = (brownoutLevelConfig != BROWNOUT_OFF_CODE) || converterEnabled
                    || (comparatorEnabled && comparatorUsesRef);

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cpuRun     <= 1'b1;
         flashClkEn <= 1'b1;
         sleeping   <= 1'b0;
         ioClkEn    <= 1'b1;
         adcClkEn   <= 1'b1;
         oscEn      <= 1'b1;
         debugActive <= 1'b0;
      end
      else
      begin
         cpuRun      <= !asleep;
         flashClkEn  <= !asleep;
         sleeping    <= asleep;
         ioClkEn     <= !asleep || ioRun;
         adcClkEn    <= !asleep || adcRun;
         oscEn       <= !asleep || oscRunMode || debugOn;
         debugActive <= debugOn;
      end
   end

   // Frozen peripherals keep state because their enable is simply withheld.
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         clkTwoWire <= 1'b1;
         clkTimer0  <= 1'b1;
         clkTimer1  <= 1'b1;
         clkTimer2  <= 1'b1;
         clkTimer3  <= 1'b1;
         clkTimer4  <= 1'b1;
         clkTimer5  <= 1'b1;
         clkSpi     <= 1'b1;
         clkSerial  <= 4'hf;
      end
      else
      begin
         clkTwoWire <= !gate0_q[G0_TWO_WIRE] && (!asleep || ioRun);
         clkTimer0  <= !gate0_q[G0_TIMER0] && (!asleep || ioRun);
         clkTimer1  <= !gate0_q[G0_TIMER1] && (!asleep || ioRun);
         clkTimer2  <= (timer2AsyncSelect || !gate0_q[G0_TIMER2]) && (!asleep || t2Run);
         clkTimer3  <= !gate1_q[3] && (!asleep || ioRun);
         clkTimer4  <= !gate1_q[4] && (!asleep || ioRun);
         clkTimer5  <= !gate1_q[5] && (!asleep || ioRun);
         clkSpi     <= !gate0_q[G0_SPI] && (!asleep || ioRun);
         clkSerial[0] <= !gate0_q[G0_SERIAL0] && (!asleep || ioRun);
         clkSerial[3:1] <= ~gate1_q[2:0] & {3{!asleep || ioRun}};
      end
   end

   // ======================================================================
   // Analog and supervisory enables.
   // ======================================================================
   logic convNow;
   assign convNow = converterEnabled && !gate0_q[G0_CONVERTER];

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         convSeen_q        <= 1'b0;
         converterOn       <= 1'b0;
         converterExtended <= 1'b1;
         comparatorOn      <= 1'b0;
         comparatorMuxOk   <= 1'b0;
         referenceOn       <= 1'b0;
         brownoutOn        <= 1'b0;
         watchdogRun       <= 1'b0;
         inputBufEn        <= 8'hff;
         inputDisable      <= 24'h000000;
      end
      else
      begin
         converterOn       <= convNow;
         converterExtended <= convNow && !convSeen_q ? 1'b1
                              : (convNow ? 1'b0 : converterExtended | !convNow);
         convSeen_q        <= convNow;
         comparatorOn      <= compOn;
         comparatorMuxOk   <= comparatorUsesMux && !gate0_q[G0_CONVERTER];
         referenceOn       <= refNeed;
         brownoutOn        <= (brownoutLevelConfig != BROWNOUT_OFF_CODE);
         watchdogRun       <= watchdogEnabled;
         inputBufEn        <= (asleep && !ioRun && !adcRun) ? wakePinMask : 8'hff;
         inputDisable      <= {indis2_q, indis1_q, indis0_q};
      end
   end
endmodule
`default_nettype wire

// *** dv/sleep_ctrl_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module sleep_ctrl_asserts
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // Register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regRdata,
   // Core and status
   input  wire logic       sleepInstr,
   input  wire logic       wakeEvent,
   input  wire logic       cpuRun,
   input  wire logic       sleeping,
   input  wire logic       watchdogEnabled,
   input  wire logic       watchdogRun,
   input  wire logic [2:0] brownoutLevelConfig,
   input  wire logic       brownoutOn,
   input  wire logic       clkTimer0,
   input  wire logic       comparatorOn,
   input  wire logic       comparatorMuxOk
);
   import sleep_pkg::*;
   logic [7:0] scQ;
   logic [7:0] g0Q;
   // ======================================================================
   // Shadow copies of what software last wrote.
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
      begin
         scQ <= 8'h00;
         g0Q <= 8'h00;
      end
      else if (regWrite)
      begin
         if (regAddr == SLEEP_CONTROL_OFF) scQ <= regWdata;
         if (regAddr == GATE0_OFF) g0Q <= regWdata;
      end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ======================================================================
   rd_idle_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
      else $error("read data not idle");
   sc_read_a: assert property ($past(regRead) && $past(regAddr) == SLEEP_CONTROL_OFF
      |-> regRdata == ($past(scQ) & 8'h0f)) else $error("sleep control readback");
   g0_read_a: assert property ($past(regRead) && $past(regAddr) == GATE0_OFF
      |-> regRdata == ($past(g0Q) & 8'hef)) else $error("gate 0 readback");
   no_enable_a: assert property (cpuRun && !sleeping && sleepInstr && !scQ[0]
      |=> !sleeping [*2]) else $error("slept without enable");
   mode_sleep_a: assert property (cpuRun && !sleeping && sleepInstr && scQ[0]
      && scQ[3:2] != 2'b10 |-> ##[1:2] sleeping) else $error("no sleep");
   wdog_run_a: assert property (watchdogEnabled [*3] |-> watchdogRun)
      else $error("watchdog stopped");
   bod_on_a: assert property ((brownoutLevelConfig != BROWNOUT_OFF_CODE) [*3]
      |-> brownoutOn) else $error("brown-out off");
   timer0_gate_a: assert property (g0Q[G0_TIMER0] [*3] |-> !clkTimer0)
      else $error("timer 0 clock runs");
   mux_gate_a: assert property (g0Q[G0_CONVERTER] [*3] |-> !comparatorMuxOk)
      else $error("mux still usable");
   deep_cmp_a: assert property ((sleeping && scQ[2] && !wakeEvent) [*3]
      |-> !comparatorOn) else $error("comparator on in deep sleep");
endmodule
bind sleep_and_power_reduction_ctrl sleep_ctrl_asserts chk (.ref_clk, .resetn, .regAddr,
   .regWdata, .regWrite, .regRead, .regRdata, .sleepInstr, .wakeEvent, .cpuRun, .sleeping,
   .watchdogEnabled, .watchdogRun, .brownoutLevelConfig, .brownoutOn, .clkTimer0,
   .comparatorOn, .comparatorMuxOk);
`default_nettype wire

// *** dv/cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_model
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Requests and core status
   input  wire logic cpuRun,
   input  wire logic sleepReq,
   input  wire logic wakeReq,
   output logic      sleepInstr,
   output logic      wakeEvent
);
   // ======================================================================
   // A sleep instruction only executes while the core runs; an interrupt
   // stays pending until the core is running its routine again.
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
      begin
         sleepInstr <= 1'b0;
         wakeEvent <= 1'b0;
      end
      else
      begin
         sleepInstr <= sleepReq && cpuRun && !sleepInstr;
         wakeEvent <= wakeReq && !cpuRun;
      end
endmodule
`default_nettype wire

// *** dv/test_sleep_and_power_reduction_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_sleep_and_power_reduction_ctrl;
   import sleep_pkg::*;
   localparam int SU = 12;
   logic ref_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic sleepReq = 1'b0, wakeReq = 1'b0, timer2AsyncSelect = 1'b0;
   logic debugEnableConfig = 1'b0, scanPortEnableConfig = 1'b1, watchdogEnabled = 1'b1;
   logic converterEnabled = 1'b1, comparatorEnabled = 1'b1;
   logic comparatorUsesRef = 1'b0, comparatorUsesMux = 1'b1;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, wakePinMask = 8'h81;
   logic [2:0] brownoutLevelConfig = 3'h6;
   logic [7:0] regRdata, inputBufEn;
   logic [3:0] clkSerial;
   logic [23:0] inputDisable;
   logic sleepInstr, wakeEvent, cpuRun, flashClkEn, sleeping, ioClkEn, adcClkEn, oscEn;
   logic clkTwoWire, clkTimer0, clkTimer1, clkTimer2, clkTimer3, clkTimer4, clkTimer5, clkSpi;
   logic converterOn, converterExtended, comparatorOn, comparatorMuxOk, referenceOn;
   logic brownoutOn, watchdogRun, debugActive;
   int fails = 0;
   int totalChecks = 0;
   always #4 ref_clk = ~ref_clk;
   sleep_and_power_reduction_ctrl #(.STARTUP(SU)) dut (.ref_clk, .resetn, .regAddr, .regWdata,
      .regWrite, .regRead, .regRdata, .sleepInstr, .wakeEvent, .cpuRun, .flashClkEn, .sleeping,
      .timer2AsyncSelect, .brownoutLevelConfig, .debugEnableConfig, .scanPortEnableConfig,
      .watchdogEnabled, .converterEnabled, .comparatorEnabled, .comparatorUsesRef,
      .comparatorUsesMux, .wakePinMask, .ioClkEn, .adcClkEn, .oscEn, .clkTwoWire, .clkTimer0,
      .clkTimer1, .clkTimer2, .clkTimer3, .clkTimer4, .clkTimer5, .clkSpi, .clkSerial,
      .converterOn, .converterExtended, .comparatorOn, .comparatorMuxOk, .referenceOn,
      .brownoutOn, .watchdogRun, .debugActive, .inputBufEn, .inputDisable);
   cpu_model core (.ref_clk, .resetn, .cpuRun, .sleepReq, .wakeReq, .sleepInstr, .wakeEvent);
   // ======================================================================
   task automatic summarize();
      $display("checks %0d mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(negedge ref_clk);
      chk(24'(regRdata), 24'(e));
   endtask
   // ======================================================================
   task automatic t_gate();
      rc(SLEEP_CONTROL_OFF, 8'h00);
      rc(GATE0_OFF, 8'h00);
      wr(SLEEP_CONTROL_OFF, 8'hfe);
      rc(SLEEP_CONTROL_OFF, 8'h0e);
      wr(SLEEP_CONTROL_OFF, 8'h00);
      wr(8'h40, 8'hff);
      rc(8'h40, 8'h00);
      wr(GATE0_OFF, 8'hff);
      wr(GATE1_OFF, 8'hff);
      rc(GATE0_OFF, 8'hef);
      rc(GATE1_OFF, 8'h3f);
      cyc(2);
      chk(24'({clkTwoWire, clkTimer2, clkTimer0, clkTimer1, clkSpi}), 24'h0);
      chk(24'({clkSerial, converterOn, comparatorMuxOk}), 24'h0);
      chk(24'({clkTimer3, clkTimer4, clkTimer5, converterExtended}), 24'h1);
      @(posedge ref_clk);
      timer2AsyncSelect <= 1'b1;
      cyc(2);
      chk(24'(clkTimer2), 24'h1);
      wr(GATE0_OFF, 8'h00);
      wr(GATE1_OFF, 8'h00);
      cyc(2);
      chk(24'({clkTwoWire, clkTimer0, clkTimer1, clkSpi, clkSerial}), 24'hff);
      chk(24'({clkTimer3, clkTimer4, clkTimer5, converterOn}), 24'hf);
      chk(24'(converterExtended), 24'h0);
   endtask
   task automatic t_sleep(input logic [2:0] m, input logic se);
      logic slow;
      int n;
      slow = m[1] && !m[2];
      wr(SLEEP_CONTROL_OFF, {4'h0, m, se});
      @(posedge ref_clk);
      sleepReq <= 1'b1;
      @(posedge ref_clk);
      sleepReq <= 1'b0;
      cyc(4);
      chk(24'(sleeping), 24'(se && m[2:1] != 2'b10));
      if (sleeping === 1'b1)
      begin
         chk(24'({cpuRun, flashClkEn, ioClkEn, adcClkEn, oscEn}),
            24'({2'b00, m == MODE_IDLE, !m[1], !slow || debugEnableConfig}));
         chk(24'(comparatorOn), 24'(!m[1]));
         chk(24'(inputBufEn), 24'(m[1] ? wakePinMask : 8'hff));
         chk(24'({converterOn, watchdogRun, brownoutOn}), 24'h7);
         @(posedge ref_clk);
         wakeReq <= 1'b1;
         n = 0;
         while (cpuRun !== 1'b1 && n < 400)
         begin
            @(negedge ref_clk);
            n++;
         end
         @(posedge ref_clk);
         wakeReq <= 1'b0;
         n = n - (slow ? SU : STANDBY_WAKE_CYCLES);
         chk(24'(n >= WAKE_HALT_CYCLES && n <= WAKE_HALT_CYCLES + 5), 24'h1);
      end
      wr(SLEEP_CONTROL_OFF, 8'h00);
   endtask
   task automatic t_misc();
      wr(INDIS0_OFF, 8'h5a);
      wr(INDIS1_OFF, 8'h03);
      wr(INDIS2_OFF, 8'hc3);
      cyc(2);
      chk(inputDisable, 24'hc3035a);
      @(posedge ref_clk);
      debugEnableConfig <= 1'b1;
      cyc(2);
      chk(24'(debugActive), 24'h1);
      t_sleep(MODE_PDOWN, 1'b1);
      wr(MCU_CONTROL_OFF, 8'h80);
      cyc(2);
      chk(24'(debugActive), 24'h0);
      rc(MCU_CONTROL_OFF, 8'h80);
      @(posedge ref_clk);
      converterEnabled <= 1'b0;
      comparatorEnabled <= 1'b0;
      brownoutLevelConfig <= BROWNOUT_OFF_CODE;
      watchdogEnabled <= 1'b0;
      cyc(3);
      chk(24'({referenceOn, watchdogRun}), 24'h0);
      @(posedge ref_clk);
      comparatorEnabled <= 1'b1;
      comparatorUsesRef <= 1'b1;
      cyc(3);
      chk(24'(referenceOn), 24'h1);
      @(posedge ref_clk);
      brownoutLevelConfig <= 3'h6;
      cyc(3);
      chk(24'(referenceOn), 24'h1);
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      t_gate();
      for (int i = 0; i < 8; i++)
         t_sleep(3'(i), 1'b1);
      t_sleep(MODE_IDLE, 1'b0);
      t_misc();
      summarize();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      summarize();
   end
endmodule
`default_nettype wire
